// File: rtl/rcs_clock_ctrl.sv
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ns
module rcs_clock_ctrl #(
  parameter int BOOT_CYCLES = rcs_pkg::BOOT_SLOW_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Oscillators
  input wire logic fast_rc_osc_i,
  input wire logic slow_rc_osc_i,
  output logic fast_osc_en_o,
  output logic slow_osc_en_o,
  output logic [7:0] fast_trim_o,
  // Calibration straps
  input wire logic [2:0] calibration_directive_i,
  input wire logic [7:0] cal_trim_i,
  // Core side
  output logic core_clock_o,
  output logic core_run_o,
  output logic [11:0] fetch_addr_o,
  output logic wdt_en_o,
  output logic port_a_pin5_input_o
);

  localparam logic [11:0] BOOT_LAST = 12'(BOOT_CYCLES - 1);

  rcs_pkg::rcs_boot_t boot_state;
  rcs_pkg::rcs_boot_t next_boot_state;
  logic [11:0] boot_cnt;
  logic [11:0] next_boot_cnt;
  logic [7:0] clkmd;
  logic [7:0] next_clkmd;
  logic [7:0] trim;
  logic [7:0] next_trim;
  logic wdt_en;
  logic next_wdt_en;
  logic cal_used;
  logic next_cal_used;
  logic pin5_in;
  logic next_pin5_in;
  logic [11:0] fetch_addr;
  logic [7:0] rdata;
  logic [7:0] next_rdata;
  logic boot_done;
  logic boot_end;
  logic fast_edge;
  logic slow_rise;
  logic slow_edge;
  logic req_slow;
  logic [5:0] req_half;
  logic src_slow;
  logic [7:0] cal_mode;
  logic cal_valid;
  logic wr_clkmd;
  logic wr_trim;

  // Oscillator inputs are asynchronous to the system clock
  rcs_edge_sync u_fast_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .osc_i(fast_rc_osc_i),
    .rise_o(),
    .edge_o(fast_edge)
  );

  rcs_edge_sync u_slow_sync (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .osc_i(slow_rc_osc_i),
    .rise_o(slow_rise),
    .edge_o(slow_edge)
  );

  assign wr_clkmd = reg_wr_i && (reg_addr_i == rcs_pkg::ADDR_CLKMD);
  assign wr_trim = reg_wr_i && (reg_addr_i == rcs_pkg::ADDR_TRIM);
  assign boot_done = (boot_state == rcs_pkg::BOOT_RUN);
  assign boot_end = !boot_done && slow_rise && (boot_cnt == BOOT_LAST);

  // Calibration strap to clock mode value
  always_comb
  begin
    cal_valid = 1'b1;
    case (calibration_directive_i)
      rcs_pkg::CAL_DIV2: cal_mode = rcs_pkg::CLKMD_FAST_DIV2;
      rcs_pkg::CAL_DIV4: cal_mode = rcs_pkg::CLKMD_FAST_DIV4;
      rcs_pkg::CAL_DIV8: cal_mode = rcs_pkg::CLKMD_FAST_DIV8;
      rcs_pkg::CAL_DIV16: cal_mode = rcs_pkg::CLKMD_FAST_DIV16;
      rcs_pkg::CAL_DIV32: cal_mode = rcs_pkg::CLKMD_FAST_DIV32;
      rcs_pkg::CAL_SLOW: cal_mode = rcs_pkg::CLKMD_SLOW;
      default:
      begin
        cal_mode = rcs_pkg::CLKMD_RST;
        cal_valid = 1'b0;
      end
    endcase
  end

  // Boot sequencer counts slow oscillator rising edges
  // boot delay count
  always_comb
  begin
    next_boot_state = boot_state;
    next_boot_cnt = boot_cnt;
    case (boot_state)
      rcs_pkg::BOOT_WAIT:
      begin
        if (slow_rise)
        begin
          if (boot_cnt == BOOT_LAST)
          begin
            next_boot_state = rcs_pkg::BOOT_RUN;
          end
          else
          begin
            next_boot_cnt = boot_cnt + 12'h001;
          end
        end
      end
      rcs_pkg::BOOT_RUN:
      begin
        next_boot_state = rcs_pkg::BOOT_RUN;
      end
      default:
      begin
        next_boot_state = rcs_pkg::BOOT_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      boot_state <= rcs_pkg::BOOT_WAIT;
      boot_cnt <= 12'h000;
    end
    else
    begin
      boot_state <= next_boot_state;
      boot_cnt <= next_boot_cnt;
    end
  end

  // Control registers; strap is taken by the clock at the end of boot,
  // never by the asynchronous reset
  always_comb
  begin
    next_clkmd = clkmd;
    next_trim = trim;
    next_wdt_en = wdt_en;
    next_cal_used = cal_used;
    next_pin5_in = pin5_in;
    if (boot_end)
    begin
      next_pin5_in = 1'b1;
      if (cal_valid)
      begin
        next_clkmd = cal_mode;
        next_trim = cal_trim_i;
        next_wdt_en = 1'b0;
        next_cal_used = 1'b1;
      end
      else
      begin
        next_wdt_en = 1'b1;
      end
    end
    else if (wr_clkmd)
    begin
      next_clkmd = reg_wdata_i;
    end
    if (wr_trim && !boot_end)
    begin
      next_trim = reg_wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      clkmd <= rcs_pkg::CLKMD_RST;
      trim <= rcs_pkg::TRIM_RST;
      wdt_en <= 1'b1;
      cal_used <= 1'b0;
      pin5_in <= 1'b1;
    end
    else
    begin
      clkmd <= next_clkmd;
      trim <= next_trim;
      wdt_en <= next_wdt_en;
      cal_used <= next_cal_used;
      pin5_in <= next_pin5_in;
    end
  end

  // Source decode; unknown codes fall back to the slow oscillator
  // divider decode
  always_comb
  begin
    req_slow = 1'b0;
    case ({clkmd[rcs_pkg::SEL_HI:rcs_pkg::SEL_LO], clkmd[rcs_pkg::SEL_B3]})
      rcs_pkg::SEL_DIV2: req_half = rcs_pkg::HALF_DIV2;
      rcs_pkg::SEL_DIV4: req_half = rcs_pkg::HALF_DIV4;
      rcs_pkg::SEL_DIV8: req_half = rcs_pkg::HALF_DIV8;
      rcs_pkg::SEL_DIV16: req_half = rcs_pkg::HALF_DIV16;
      rcs_pkg::SEL_DIV32: req_half = rcs_pkg::HALF_DIV32;
      default:
      begin
        req_half = rcs_pkg::HALF_SLOW;
        req_slow = 1'b1;
      end
    endcase
  end

  // Glitch-free divider and source switch
  rcs_clk_mux u_mux (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .fast_edge_i(fast_edge),
    .slow_edge_i(slow_edge),
    .req_slow_i(req_slow),
    .req_half_i(req_half),
    .core_clock_o(core_clock_o),
    .src_slow_o(src_slow)
  );

  // Read data, valid one cycle after the strobe; unmapped reads give zero
  always_comb
  begin
    next_rdata = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        rcs_pkg::ADDR_CLKMD: next_rdata = clkmd;
        rcs_pkg::ADDR_TRIM: next_rdata = trim;
        rcs_pkg::ADDR_STATUS:
        begin
          next_rdata[rcs_pkg::ST_SRC_SLOW] = src_slow;
          next_rdata[rcs_pkg::ST_BOOT_DONE] = boot_done;
          next_rdata[rcs_pkg::ST_WDT_EN] = wdt_en;
          next_rdata[rcs_pkg::ST_CAL_USED] = cal_used;
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      rdata <= 8'h00;
      fetch_addr <= rcs_pkg::RESET_VECTOR;
    end
    else
    begin
      rdata <= next_rdata;
      fetch_addr <= rcs_pkg::RESET_VECTOR;
    end
  end

  assign fast_osc_en_o = clkmd[rcs_pkg::FAST_EN_BIT];
  assign slow_osc_en_o = clkmd[rcs_pkg::SLOW_EN_BIT];
  assign fast_trim_o = trim;
  assign reg_rdata_o = rdata;
  assign core_run_o = boot_done;
  assign fetch_addr_o = fetch_addr;
  assign wdt_en_o = wdt_en;
  assign port_a_pin5_input_o = pin5_in;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence s_last_slow;
    slow_rise && (boot_cnt == BOOT_LAST) && !boot_done;
  endsequence

  property p_boot_hold;
    $rose(core_run_o) |-> $past(slow_rise) && ($past(boot_cnt) == BOOT_LAST);
  endproperty
  a_boot_hold: assert property (p_boot_hold) else $error("core freed early");

  property p_vector;
    core_run_o |-> fetch_addr_o == rcs_pkg::RESET_VECTOR;
  endproperty
  a_vector: assert property (p_vector) else $error("bad start address");

  property p_enables;
    wr_clkmd && !boot_end |=> fast_osc_en_o == $past(reg_wdata_i[rcs_pkg::FAST_EN_BIT])
      && slow_osc_en_o == $past(reg_wdata_i[rcs_pkg::SLOW_EN_BIT]);
  endproperty
  a_enables: assert property (p_enables) else $error("enable not taken");

  property p_boot_slow;
    !core_run_o |-> !fast_osc_en_o && slow_osc_en_o;
  endproperty
  a_boot_slow: assert property (p_boot_slow) else $error("fast on during boot");

  property p_trim;
    wr_trim && !boot_end |=> fast_trim_o == $past(reg_wdata_i);
  endproperty
  a_trim: assert property (p_trim) else $error("trim not taken");

  property p_div_decode;
    (clkmd == rcs_pkg::CLKMD_FAST_DIV2 |-> req_half == rcs_pkg::HALF_DIV2)
      and (clkmd == rcs_pkg::CLKMD_FAST_DIV8 |-> req_half == rcs_pkg::HALF_DIV8)
      and (clkmd == rcs_pkg::CLKMD_FAST_DIV32 |-> req_half == rcs_pkg::HALF_DIV32);
  endproperty
  a_div_decode: assert property (p_div_decode) else $error("divider decode wrong");

  property p_slow_sel;
    clkmd == rcs_pkg::CLKMD_SLOW |-> req_slow && !fast_osc_en_o;
  endproperty
  a_slow_sel: assert property (p_slow_sel) else $error("slow select wrong");

  property p_cal_load;
    s_last_slow ##0 cal_valid |=> clkmd == $past(cal_mode) && !wdt_en_o
      && slow_osc_en_o && port_a_pin5_input_o;
  endproperty
  a_cal_load: assert property (p_cal_load) else $error("calibrated boot wrong");

  property p_cal_off;
    s_last_slow ##0 !cal_valid |=> clkmd == rcs_pkg::CLKMD_RST && wdt_en_o && !fast_osc_en_o;
  endproperty
  a_cal_off: assert property (p_cal_off) else $error("plain boot wrong");

endmodule

// File: rtl/rcs_pkg.sv
// Functional notes
// - Hold the core for 2900 slow oscillator cycles after power-on reset.
// - Released core starts fetching at program address 0x000.
// - Clock mode bit 4 enables fast oscillator, bit 2 the slow one.
// - During boot only the slow oscillator runs; fast one is off. Reset sets this, but clock mode writes during boot are still taken.
// - A trim register adjusts fast oscillator frequency, usually toward 16MHz.
// - Mode 34h gives fast/2, 14h fast/4, 3Ch fast/8, slow kept on.
// - Mode 1Ch gives fast/16 and 7Ch gives fast/32 as system clock.
// - Mode E4h selects the undivided slow oscillator, fast oscillator off.
// - Calibration option loads chosen mode, watchdog off, slow on, pin 5 input.
// - Calibration disabled keeps reset mode, fast off, slow clock, watchdog on.
// - A clock mode write changes source or divider at the next core clock fall.
package rcs_pkg;

  // Register indices on the plain register port
  localparam logic [3:0] ADDR_CLKMD = 4'h0;
  localparam logic [3:0] ADDR_TRIM = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;

  // Clock mode register fields
  localparam int FAST_EN_BIT = 4;
  localparam int SLOW_EN_BIT = 2;
  localparam int SEL_HI = 7;
  localparam int SEL_LO = 5;
  localparam int SEL_B3 = 3;

  // Clock mode values
  localparam logic [7:0] CLKMD_FAST_DIV2 = 8'h34;
  localparam logic [7:0] CLKMD_FAST_DIV4 = 8'h14;
  localparam logic [7:0] CLKMD_FAST_DIV8 = 8'h3C;
  localparam logic [7:0] CLKMD_FAST_DIV16 = 8'h1C;
  localparam logic [7:0] CLKMD_FAST_DIV32 = 8'h7C;
  localparam logic [7:0] CLKMD_SLOW = 8'hE4;
  localparam logic [7:0] CLKMD_RST = 8'hE4;

  // Source select codes formed from clock mode bits 7:5 and 3
  localparam logic [3:0] SEL_DIV2 = 4'h2;
  localparam logic [3:0] SEL_DIV4 = 4'h0;
  localparam logic [3:0] SEL_DIV8 = 4'h3;
  localparam logic [3:0] SEL_DIV16 = 4'h1;
  localparam logic [3:0] SEL_DIV32 = 4'h7;
  localparam logic [3:0] SEL_SLOW = 4'hE;

  // Oscillator edges per half period of the core clock
  localparam logic [5:0] HALF_DIV2 = 6'h02;
  localparam logic [5:0] HALF_DIV4 = 6'h04;
  localparam logic [5:0] HALF_DIV8 = 6'h08;
  localparam logic [5:0] HALF_DIV16 = 6'h10;
  localparam logic [5:0] HALF_DIV32 = 6'h20;
  localparam logic [5:0] HALF_SLOW = 6'h01;

  // Boot and reset figures
  localparam int BOOT_SLOW_CYCLES = 2900;
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam logic [7:0] TRIM_RST = 8'h80;

  // Status register bits
  localparam int ST_SRC_SLOW = 0;
  localparam int ST_BOOT_DONE = 1;
  localparam int ST_WDT_EN = 2;
  localparam int ST_CAL_USED = 3;

  // Calibration option strap
  typedef enum logic [2:0] {
    CAL_DISABLE = 3'h0,
    CAL_DIV2 = 3'h1,
    CAL_DIV4 = 3'h2,
    CAL_DIV8 = 3'h3,
    CAL_DIV16 = 3'h4,
    CAL_DIV32 = 3'h5,
    CAL_SLOW = 3'h6
  } rcs_cal_t;

  // Boot sequencer states
  typedef enum logic [0:0] {
    BOOT_WAIT = 1'b0,
    BOOT_RUN = 1'b1
  } rcs_boot_t;

endpackage

// File: rtl/rcs_edge_sync.sv
`timescale 1ns/1ns
module rcs_edge_sync (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Oscillator level
  input wire logic osc_i,
  // Edge events
  output logic rise_o,
  output logic edge_o
);

  logic meta;
  logic stable;
  logic prev;
  logic next_meta;
  logic next_stable;
  logic next_prev;
  logic [2:0] fill;
  logic [2:0] next_fill;

  // First stage feeds only the second; edges compare second and third.
  // The pin may already be high when reset ends, so edges count only once
  // the whole chain holds samples taken after reset
  always_comb
  begin
    next_meta = osc_i;
    next_stable = meta;
    next_prev = stable;
    next_fill = {fill[1:0], 1'b1};
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
      fill <= 3'h0;
    end
    else
    begin
      meta <= next_meta;
      stable <= next_stable;
      prev <= next_prev;
      fill <= next_fill;
    end
  end

  // Edge pulses, one cycle each, masked until the chain is filled
  assign rise_o = fill[2] & stable & ~prev;
  assign edge_o = fill[2] & (stable ^ prev);

endmodule

// File: rtl/rcs_clk_mux.sv
`timescale 1ns/1ns
module rcs_clk_mux (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Oscillator edge events
  input wire logic fast_edge_i,
  input wire logic slow_edge_i,
  // Requested source
  input wire logic req_slow_i,
  input wire logic [5:0] req_half_i,
  // Core clock
  output logic core_clock_o,
  output logic src_slow_o
);

  logic cur_slow;
  logic [5:0] cur_half;
  logic [5:0] cnt;
  logic out;
  logic tick;
  logic next_cur_slow;
  logic [5:0] next_cur_half;
  logic [5:0] next_cnt;
  logic out_next;

  // Count edges of the active source; a new choice is taken only at a
  // falling edge, so the high phase ends whole and the low phase is new
  // glitch-free switch
  always_comb
  begin
    tick = cur_slow ? slow_edge_i : fast_edge_i;
    next_cur_slow = cur_slow;
    next_cur_half = cur_half;
    next_cnt = cnt;
    out_next = out;
    if (tick)
    begin
      if (cnt == cur_half - 6'h01)
      begin
        out_next = ~out;
        next_cnt = 6'h00;
        if (out)
        begin
          next_cur_slow = req_slow_i;
          next_cur_half = req_half_i;
        end
      end
      else
      begin
        next_cnt = cnt + 6'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
    begin
      cur_slow <= 1'b1;
      cur_half <= rcs_pkg::HALF_SLOW;
      cnt <= 6'h00;
      out <= 1'b0;
    end
    else
    begin
      cur_slow <= next_cur_slow;
      cur_half <= next_cur_half;
      cnt <= next_cnt;
      out <= out_next;
    end
  end

  assign core_clock_o = out;
  assign src_slow_o = cur_slow;

  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_no_runt;
    $changed(out) |-> $past(tick) && ($past(cnt) == $past(cur_half) - 6'h01);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("core clock toggled early");

  property p_switch_low;
    $changed(cur_half) |-> !out && $past(out);
  endproperty
  a_switch_low: assert property (p_switch_low) else $error("switch outside fall");

endmodule

// File: verification/tb.sv
`timescale 1ns/1ns
module tb;
  localparam int BOOT = 4;
  // Oscillator half periods in system clock cycles
  localparam int FAST_HALF = 3;
  localparam int SLOW_HALF = 11;
  localparam int WIN = 2000;
  // Stimulus
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic fast_rc_osc_i = 1'b0;
  logic slow_rc_osc_i = 1'b0;
  logic [2:0] calibration_directive_i = 3'h0;
  logic [7:0] cal_trim_i = 8'h00;
  // Observed
  logic [7:0] reg_rdata_o;
  logic [7:0] fast_trim_o;
  logic [11:0] fetch_addr_o;
  logic fast_osc_en_o, slow_osc_en_o, core_clock_o, core_run_o, wdt_en_o, port_a_pin5_input_o;
  // Bench state
  int n_fail = 0;
  int check_count = 0;
  int n_slow = 0;
  int n_rise = 0;
  int hi_len = 0;
  int min_hi = 100;
  logic armed = 1'b0;
  logic ck_d = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  logic [7:0] md_tab [7] = '{rcs_pkg::CLKMD_RST, rcs_pkg::CLKMD_FAST_DIV2,
    rcs_pkg::CLKMD_FAST_DIV4, rcs_pkg::CLKMD_FAST_DIV8, rcs_pkg::CLKMD_FAST_DIV16,
    rcs_pkg::CLKMD_FAST_DIV32, rcs_pkg::CLKMD_SLOW};
  int h_tab [7] = '{1, 2, 4, 8, 16, 32, 1};

  rcs_clock_ctrl #(
    .BOOT_CYCLES(BOOT)
  ) dut (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o),
    .fast_rc_osc_i(fast_rc_osc_i),
    .slow_rc_osc_i(slow_rc_osc_i),
    .fast_osc_en_o(fast_osc_en_o),
    .slow_osc_en_o(slow_osc_en_o),
    .fast_trim_o(fast_trim_o),
    .calibration_directive_i(calibration_directive_i),
    .cal_trim_i(cal_trim_i),
    .core_clock_o(core_clock_o),
    .core_run_o(core_run_o),
    .fetch_addr_o(fetch_addr_o),
    .wdt_en_o(wdt_en_o),
    .port_a_pin5_input_o(port_a_pin5_input_o)
  );

  // System clock, 10 ns period
  initial
  begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Oscillators stop when disabled, so a wrong switch sequence would stall the core clock;
  // levels move on clock edges so the synchronisers never race the bench
  initial
  begin
    forever
    begin
      repeat (FAST_HALF) @(posedge clk_sys_i);
      if (fast_osc_en_o === 1'b1)
        fast_rc_osc_i <= ~fast_rc_osc_i;
    end
  end
  initial
  begin
    forever
    begin
      repeat (SLOW_HALF) @(posedge clk_sys_i);
      if (slow_osc_en_o === 1'b1)
        slow_rc_osc_i <= ~slow_rc_osc_i;
    end
  end

  // Slow rising edges since reset release
  always @(posedge slow_rc_osc_i or posedge sys_rst_i)
  begin
    if (sys_rst_i)
      n_slow <= 0;
    else
      n_slow <= n_slow + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Read answers stand only in the cycle after the strobe
  always @(posedge clk_sys_i)
    rd_d <= reg_rd_i;
  always @(negedge clk_sys_i)
  begin
    if (rd_d)
      check({8'h00, reg_rdata_o}, {8'h00, exp_q.pop_front()});
    else
      check({8'h00, reg_rdata_o}, 16'h0000);
  end

  // Core clock rise count and shortest high phase; reset may cut a phase, so disarm there
  always @(negedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      armed <= 1'b0;
      hi_len <= 0;
    end
    else
    begin
      if (core_clock_o && !ck_d)
        n_rise <= n_rise + 1;
      if (core_clock_o)
        hi_len <= hi_len + 1;
      if (!core_clock_o && ck_d)
      begin
        if (armed && hi_len < min_hi)
          min_hi <= hi_len;
        armed <= core_run_o;
        hi_len <= 0;
      end
    end
    ck_d <= core_clock_o;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    exp_q.push_back(e);
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
  endtask

  // Rise count over a window against the divider ratio, sync jitter allowed
  task automatic measure(input int h, input int half);
    int n0;
    int expn;
    repeat (300) @(posedge clk_sys_i);
    n0 = n_rise;
    repeat (WIN) @(posedge clk_sys_i);
    expn = WIN / (2 * h * half);
    check(16'((n_rise - n0 >= expn - 2) && (n_rise - n0 <= expn + 2)), 16'h0001);
  endtask

  task automatic boot(input logic [2:0] strap);
    int i;
    @(posedge clk_sys_i);
    cal_trim_i <= 8'($urandom);
    calibration_directive_i <= strap;
    sys_rst_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    #1;
    check(16'({fast_osc_en_o, slow_osc_en_o, core_run_o, wdt_en_o, port_a_pin5_input_o}),
      16'h000B);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    i = 0;
    while (core_run_o !== 1'b1 && i < 500)
    begin
      @(posedge clk_sys_i);
      #1;
      i++;
    end
    // A boot that never ends counts once; the run still reaches the report
    if (i == 500)
      n_fail++;
    // A rise in the very cycle of release may be counted here but not by the block
    check(16'(n_slow >= BOOT && n_slow <= BOOT + 1), 16'h0001);
    check(16'(fetch_addr_o), 16'h0000);
  endtask

  initial
  begin
    logic [7:0] tv;
    logic [7:0] m;
    int s;
    void'($urandom(16110));
    // Every strap option, disable last so the watchdog stays on afterwards
    for (int k = 1; k < 8; k++)
    begin
      s = k % 7;
      boot(3'(s));
      check(16'({wdt_en_o, port_a_pin5_input_o}), 16'({s == 0, 1'b1}));
      check(16'({fast_osc_en_o, slow_osc_en_o}), 16'({md_tab[s][4], 1'b1}));
      rd(rcs_pkg::ADDR_CLKMD, md_tab[s]);
      rd(rcs_pkg::ADDR_TRIM, (s == 0) ? rcs_pkg::TRIM_RST : cal_trim_i);
      measure(h_tab[s], (h_tab[s] == 1) ? SLOW_HALF : FAST_HALF);
      rd(rcs_pkg::ADDR_STATUS, {4'h0, s != 0, s == 0, 1'b1, h_tab[s] == 1});
    end
    // Trim write, read-only status, unmapped index
    tv = 8'($urandom);
    wr(rcs_pkg::ADDR_TRIM, tv);
    check({8'h00, fast_trim_o}, {8'h00, tv});
    rd(rcs_pkg::ADDR_TRIM, tv);
    wr(rcs_pkg::ADDR_STATUS, 8'hFF);
    rd(rcs_pkg::ADDR_STATUS, 8'h07);
    rd(4'hF, 8'h00);
    // Software switching sequences, each fast divider mode from the slow clock and back
    for (int k = 1; k < 6; k++)
    begin
      m = rcs_pkg::CLKMD_SLOW | 8'h10;
      wr(rcs_pkg::ADDR_CLKMD, m);
      check(16'({fast_osc_en_o, slow_osc_en_o}), 16'h0003);
      wr(rcs_pkg::ADDR_CLKMD, md_tab[k]);
      rd(rcs_pkg::ADDR_CLKMD, md_tab[k]);
      measure(h_tab[k], FAST_HALF);
      rd(rcs_pkg::ADDR_STATUS, 8'h06);
      wr(rcs_pkg::ADDR_CLKMD, md_tab[k] & 8'hFB);
      check(16'({fast_osc_en_o, slow_osc_en_o}), 16'h0002);
      wr(rcs_pkg::ADDR_CLKMD, md_tab[k]);
      // fast kept on while leaving it
      wr(rcs_pkg::ADDR_CLKMD, m);
      measure(1, SLOW_HALF);
      wr(rcs_pkg::ADDR_CLKMD, rcs_pkg::CLKMD_SLOW);
      check(16'({fast_osc_en_o, slow_osc_en_o}), 16'h0001);
    end
    measure(1, SLOW_HALF);
    check(16'(min_hi >= 3), 16'h0001);
    close_out();
  end
endmodule
